// File: dv/t16w_core_model.sv
// Counter core model that steps the count for the waveform unit
`timescale 1ns/1ps
module t16w_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Bench control
    input wire logic run,
    input wire logic [1:0] tick_div,
    input wire logic load,
    input wire logic [15:0] load_value,
    // Counter link
    input wire logic [15:0] top_value,
    input wire t16w_pkg::t16w_class_t wave_class,
    output logic [15:0] cnt_value,
    output logic cnt_tick,
    output logic cnt_up
);
    import t16w_pkg::*;
    logic [1:0] div_ff;
    // A slow prescale spaces the steps out, as a real timer clock would
    assign cnt_tick = run && (div_ff == tick_div);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div_ff <= 2'h0;
            cnt_value <= 16'h0000;
            cnt_up <= 1'b1;
        end else if (load) begin
            div_ff <= 2'h0;
            cnt_value <= load_value;
            cnt_up <= 1'b1;
        end else begin
            div_ff <= (div_ff >= tick_div) ? 2'h0 : div_ff + 2'h1;
            if (cnt_tick && wave_class != T16W_CLS_DUAL) begin
                cnt_value <= (cnt_value == top_value) ? 16'h0000 :
                    cnt_value + 16'h0001;
                cnt_up <= 1'b1;
            end else if (cnt_tick && cnt_up) begin
                // Turns at TOP; a count left above TOP also heads down
                cnt_value <= (cnt_value >= top_value) ?
                    cnt_value - 16'h0001 : cnt_value + 16'h0001;
                cnt_up <= cnt_value < top_value;
            end else if (cnt_tick) begin
                cnt_value <= (cnt_value == 16'h0000) ? 16'h0001 :
                    cnt_value - 16'h0001;
                cnt_up <= cnt_value == 16'h0000;
            end
        end
    end
endmodule // t16w_core_model

// File: dv/test_t16w_wave.sv
// Self-checking bench of the timer waveform unit
`timescale 1ns/1ps
`include "t16w_defs.svh"
module test_t16w_wave;
    import t16w_pkg::*;
    logic clk_sys, reset_n, clk_en, reg_wr, reg_rd, irq, ovf, ld, run;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, top_value, cnt_value, ld_val;
    logic cnt_tick, cnt_up, pd_a, pd_b, dir_a, dir_b;
    logic wo_a, wo_b, oe_n_a, oe_n_b;
    logic rd_seen = 1'b0;
    logic [1:0] div;
    t16w_class_t wave_class;
    logic [15:0] exp_q[$];
    logic [7:0] addrs[8] = '{8'h80, 8'h81, 8'h86, 8'h90, 8'h92, 8'ha0,
        8'ha1, 8'h99};
    logic [3:0] mds[5] = '{4'hc, 4'he, 4'ha, 4'hb, 4'h5};
    logic [3:0] om[5] = '{4'he, 4'ha, 4'h8, 4'h0, 4'hc};
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    t16w_wave i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_value(cnt_value),
        .cnt_tick(cnt_tick), .cnt_up(cnt_up), .top_value(top_value),
        .wave_class(wave_class), .overflow_flag(ovf), .port_data_a(pd_a),
        .port_data_b(pd_b), .port_dir_a(dir_a), .port_dir_b(dir_b),
        .wave_out_a(wo_a), .wave_out_b(wo_b), .wave_oe_n_a(oe_n_a),
        .wave_oe_n_b(oe_n_b), .irq(irq));
    t16w_core_model i_core (.clk_sys(clk_sys), .reset_n(reset_n),
        .run(run), .tick_div(div), .load(ld), .load_value(ld_val),
        .top_value(top_value), .wave_class(wave_class),
        .cnt_value(cnt_value), .cnt_tick(cnt_tick), .cnt_up(cnt_up));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: port %h, expected %h", $time, got, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_seen <= reg_rd && clk_en && reset_n;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            results();
        end
    end
    always @(negedge clk_sys) begin
        if (rd_seen) chk_rd(reg_rdata, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Restarting the count keeps every run clear of long wraps
    task automatic set_mode(input logic [3:0] m, input logic [1:0] ca,
            input logic [1:0] cb);
        wr(`T16W_ADDR_CTRL_A, {8'h00, ca, cb, 2'h0, m[1:0]});
        wr(`T16W_ADDR_CTRL_B, {11'h000, m[3:2], 3'h0});
        ld <= 1'b1;
        @(posedge clk_sys);
        ld <= 1'b0;
    endtask

    task automatic wait_cnt(input logic [15:0] v, input logic up);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge clk_sys);
            if (cnt_value === v && cnt_up === up && cnt_tick === 1'b1) break;
        end
        if (i == 3000) begin
            n_mismatch++;
            $display("mismatch at %0t: count %h never reached", $time, v);
        end
    endtask

    task automatic two_per(input logic [15:0] sb, input logic [15:0] sa,
            input logic ua, output logic a1, output logic a2,
            output logic b1, output logic b2);
        wait_cnt(sb, 1'b1);
        b1 = wo_b;
        wait_cnt(sa, ua);
        a1 = wo_a;
        wait_cnt(sb, 1'b1);
        b2 = wo_b;
        wait_cnt(sa, ua);
        a2 = wo_a;
    endtask

    // Level after a match event; toggle only where the mode allows it
    function automatic logic exp_lvl(input logic [1:0] c, input logic p1,
            input logic pd, input logic tog);
        if (c == 2'h0 || (c == 2'h1 && !tog)) return pd;
        if (c == 2'h1) return !p1;
        return c == 2'h3;
    endfunction

    function automatic logic [17:0] mode_exp(input logic [3:0] m,
            input logic [15:0] cap, input logic [15:0] ma);
        logic [15:0] t;
        t16w_class_t c;
        case (m)
            4'h1, 4'h5: t = `T16W_TOP_8BIT;
            4'h2, 4'h6: t = `T16W_TOP_9BIT;
            4'h3, 4'h7: t = `T16W_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: t = ma;
            4'h8, 4'ha, 4'hc, 4'he: t = cap;
            default: t = `T16W_MAX;
        endcase
        if (m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) c = T16W_CLS_FAST;
        else if (m inside {[4'h1:4'h3], [4'h8:4'hb]}) c = T16W_CLS_DUAL;
        else c = T16W_CLS_NONPWM;
        return {c, t};
    endfunction

    initial begin
        int c;
        logic [15:0] cap, ma, mb, sa;
        logic [17:0] e;
        logic a1, a2, b1, b2;
        {reset_n, reg_wr, reg_rd, run, ld, pd_a, pd_b, dir_a, dir_b} = 9'h000;
        {clk_en, reg_addr, reg_wdata, ld_val, div} = {1'b1, 42'h0};
        void'($urandom(71743));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk_out(top_value, `T16W_MAX);
        chk_out(wave_class, T16W_CLS_NONPWM);
        chk_out(oe_n_a, 1'b1);
        foreach (addrs[k]) rd(addrs[k], 16'h0000);
        wr(`T16W_ADDR_CTRL_A, 16'hffff);
        rd(`T16W_ADDR_CTRL_A, 16'h00f3);
        wr(`T16W_ADDR_CTRL_B, 16'hffff);
        rd(`T16W_ADDR_CTRL_B, 16'h00df);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(`T16W_ADDR_IRQ_MASK, 16'h0007);
        clk_en <= 1'b1;
        rd(`T16W_ADDR_IRQ_MASK, 16'h0000);
        // Software enables the pin drivers
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        cap = 16'h0020 + 16'($urandom_range(0, 31));
        ma = cap - 16'h0008 - 16'($urandom_range(0, 7));
        mb = 16'h0008 + 16'($urandom_range(0, 5));
        set_mode(4'h0, 2'h0, 2'h0);
        wr(`T16W_ADDR_CAPTURE, cap);
        wr(`T16W_ADDR_MATCH_A, ma);
        wr(`T16W_ADDR_MATCH_B, mb);
        rd(`T16W_ADDR_CAPTURE, cap);
        chk_out(oe_n_b, 1'b0);
        for (c = 0; c < 16; c++) begin
            set_mode(c[3:0], 2'h0, 2'h0);
            @(negedge clk_sys);
            e = mode_exp(c[3:0], cap, ma);
            chk_out(top_value, e[15:0]);
            chk_out(wave_class, e[17:16]);
        end
        run <= 1'b1;
        foreach (mds[k]) begin
            for (c = 0; c < 4; c++) begin
                if (mds[k] == 4'hb && c > 1) continue;
                @(posedge clk_sys);
                pd_a <= 1'($urandom);
                pd_b <= 1'($urandom);
                div <= 2'($urandom_range(0, 2));
                set_mode(mds[k], c[1:0], c[1:0]);
                sa = (mds[k] == 4'hb) ? ma - 16'h0003 : ma + 16'h0003;
                two_per(mb + 16'h0003, sa, mds[k] != 4'hb, a1, a2, b1, b2);
                b1 = exp_lvl(c[1:0], b1, pd_b, mds[k] == 4'hc);
                a1 = exp_lvl(c[1:0], a1, pd_a, mds[k] inside {4'hc, 4'he, 4'hb});
                chk_out(a2, a1);
                chk_out(b2, b1);
                if (c > 1 && mds[k] inside {4'he, 4'h5}) begin
                    wait_cnt(16'h0003, 1'b1);
                    chk_out(wo_a, c == 2);
                    chk_out(wo_b, c == 2);
                end
                if (c > 1 && mds[k] == 4'ha) begin
                    wait_cnt(ma - 16'h0003, 1'b0);
                    chk_out(wo_a, c == 2);
                    wait_cnt(mb - 16'h0003, 1'b0);
                    chk_out(wo_b, c == 2);
                end
            end
        end
        // Compare value at TOP: only the BOTTOM action may move the pin
        div <= 2'h0;
        wr(`T16W_ADDR_MATCH_A, cap);
        for (c = 2; c < 4; c++) begin
            set_mode(4'he, c[1:0], 2'h0);
            wait_cnt(16'h0001, 1'b1);
            wait_cnt(16'h0001, 1'b1);
            chk_out(wo_a, c == 2);
        end
        foreach (om[k]) begin
            ld_val <= (om[k] == 4'h0) ? 16'hfff0 : 16'h0000;
            set_mode(om[k], 2'h0, 2'h0);
            if (om[k] inside {4'ha, 4'h8}) wait_cnt(16'h0000, 1'b0);
            else if (om[k] == 4'h0) wait_cnt(`T16W_MAX, 1'b1);
            else wait_cnt(cap, 1'b1);
            chk_out(ovf, om[k] != 4'hc);
            wait_cnt(16'h0005, 1'b1);
            chk_out(ovf, 1'b0);
        end
        @(posedge clk_sys);
        run <= 1'b0;
        ld_val <= 16'h0000;
        rd(`T16W_ADDR_IRQ_STAT, 16'h0007);
        chk_out(irq, 1'b0);
        wr(`T16W_ADDR_IRQ_MASK, 16'h0002);
        @(negedge clk_sys);
        chk_out(irq, 1'b1);
        wr(`T16W_ADDR_IRQ_STAT, 16'h0002);
        @(negedge clk_sys);
        chk_out(irq, 1'b0);
        rd(`T16W_ADDR_IRQ_STAT, 16'h0005);
        rd(`T16W_ADDR_IRQ_MASK, 16'h0002);
        results();
    end
endmodule // test_t16w_wave

// File: inc/t16w_defs.svh
// Offsets, field positions, codes and fixed values of the waveform unit
`ifndef T16W_DEFS_SVH
`define T16W_DEFS_SVH

// Register offsets
`define T16W_ADDR_CTRL_A 8'h80
`define T16W_ADDR_CTRL_B 8'h81
`define T16W_ADDR_CAPTURE 8'h86
`define T16W_ADDR_MATCH_A 8'h90
`define T16W_ADDR_MATCH_B 8'h92
`define T16W_ADDR_IRQ_STAT 8'ha0
`define T16W_ADDR_IRQ_MASK 8'ha1

// Field positions
`define T16W_FLD_OUT_A 7:6
`define T16W_FLD_OUT_B 5:4
`define T16W_FLD_WAVE_LO 1:0
`define T16W_FLD_WAVE_HI 4:3
`define T16W_CTRL_A_MASK 8'hf3
`define T16W_CTRL_B_MASK 8'hdf
`define T16W_IRQ_OVF 0
`define T16W_IRQ_MATCH_A 1
`define T16W_IRQ_MATCH_B 2

// Reset values
`define T16W_RST_8 8'h00
`define T16W_RST_16 16'h0000
`define T16W_RST_IRQ 3'h0

// Output mode codes
`define T16W_OUT_OFF 2'h0
`define T16W_OUT_TOGGLE 2'h1
`define T16W_OUT_CLEAR 2'h2
`define T16W_OUT_SET 2'h3

// Waveform modes
`define T16W_M_NORMAL 4'h0
`define T16W_M_PC8 4'h1
`define T16W_M_PC9 4'h2
`define T16W_M_PC10 4'h3
`define T16W_M_CTC_MA 4'h4
`define T16W_M_FP8 4'h5
`define T16W_M_FP9 4'h6
`define T16W_M_FP10 4'h7
`define T16W_M_PFC_CAP 4'h8
`define T16W_M_PFC_MA 4'h9
`define T16W_M_PC_CAP 4'ha
`define T16W_M_PC_MA 4'hb
`define T16W_M_CTC_CAP 4'hc
`define T16W_M_RESERVED 4'hd
`define T16W_M_FP_CAP 4'he
`define T16W_M_FP_MA 4'hf

// Fixed counter values
`define T16W_TOP_8BIT 16'h00ff
`define T16W_TOP_9BIT 16'h01ff
`define T16W_TOP_10BIT 16'h03ff
`define T16W_MAX 16'hffff
`define T16W_BOTTOM 16'h0000

`endif

// File: inc/t16w_pkg.sv
// Types of the timer waveform unit
package t16w_pkg;

    // Waveform family picked by the mode
    typedef enum logic [1:0] {
        T16W_CLS_NONPWM,
        T16W_CLS_FAST,
        T16W_CLS_DUAL
    } t16w_class_t;

    // Where the active match values are reloaded
    typedef enum logic [1:0] {
        T16W_UPD_NOW,
        T16W_UPD_TOP,
        T16W_UPD_BOTTOM
    } t16w_upd_t;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] capture;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic wave_a;
        logic wave_b;
        logic pin_a;
        logic pin_b;
        logic drv_a;
        logic drv_b;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [15:0] rdata;
    } t16w_state_t;

endpackage

// File: verilog/t16w_wave.sv
// Waveform mode decode and compare output unit of a 16-bit timer
`timescale 1ns/1ps
`include "t16w_defs.svh"

// Summary of operation
// [R1] A nonzero output code hands the channel's pin to its waveform output.
// [R2] Software sets the pin's direction bit, else the driver stays off.
// [R3] Non-PWM codes: off, toggle, clear, set on compare match.
// [R4] Fast PWM code 01 toggles A only in modes 14, 15; B off.
// [R5] Fast PWM code 10 clears on match and sets at BOTTOM.
// [R6] Fast PWM code 11 sets on match and clears at BOTTOM.
// [R7] Fast PWM codes 10, 11 ignore a match at TOP but still act at BOTTOM.
// [R8] Dual-slope code 01 toggles A only in modes 9, 11; B off.
// [R9] Dual-slope code 10 clears on up match, sets on down match.
// [R10] Dual-slope code 11 sets on up match, clears on down match.
// [R11] Mode is two bits of control A plus two bits of control B.
// [R12] Modes 0, 4, 12: fixed or register TOP, update now, overflow at MAX.
// [R13] Phase-correct TOPs 0xFF, 0x1FF, 0x3FF or register; update TOP.
// [R14] Fast PWM TOPs likewise; update at BOTTOM, overflow at TOP.
// [R15] Modes 8, 9 take TOP from capture or match A; BOTTOM events.
// [R16] Output codes are read according to the current mode family.
// [R17] Reserved mode 13 counts normally with both outputs disconnected.
module t16w_wave (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Counter core
    input wire logic [15:0] cnt_value,
    input wire logic cnt_tick,
    input wire logic cnt_up,
    output logic [15:0] top_value,
    output t16w_pkg::t16w_class_t wave_class,
    output logic overflow_flag,
    // Port pins
    input wire logic port_data_a,
    input wire logic port_data_b,
    input wire logic port_dir_a,
    input wire logic port_dir_b,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_oe_n_a,
    output logic wave_oe_n_b,
    // Interrupt
    output logic irq
);
    import t16w_pkg::*;

    t16w_state_t st_ff;
    t16w_state_t nxt_st;

    logic [3:0] waveform_mode_sel;
    logic [1:0] out_mode_chan_a;
    logic [1:0] out_mode_chan_b;
    t16w_class_t cls;
    t16w_upd_t upd;
    logic [15:0] top;
    logic step;
    logic at_top;
    logic at_bot;
    logic at_max;
    logic match_a;
    logic match_b;
    logic conn_a;
    logic conn_b;
    logic ovf_evt;
    logic reload;

    function automatic t16w_class_t mode_class(input logic [3:0] m);
        case (m)
            `T16W_M_PC8, `T16W_M_PC9, `T16W_M_PC10, `T16W_M_PFC_CAP,
            `T16W_M_PFC_MA, `T16W_M_PC_CAP, `T16W_M_PC_MA: begin
                mode_class = T16W_CLS_DUAL;
            end
            `T16W_M_FP8, `T16W_M_FP9, `T16W_M_FP10, `T16W_M_FP_CAP,
            `T16W_M_FP_MA: begin
                mode_class = T16W_CLS_FAST;
            end
            default: begin
                mode_class = T16W_CLS_NONPWM;
            end
        endcase
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m,
                                           input logic [15:0] cap,
                                           input logic [15:0] ma);
        case (m)
            `T16W_M_PC8, `T16W_M_FP8: begin
                top_of = `T16W_TOP_8BIT;
            end
            `T16W_M_PC9, `T16W_M_FP9: begin
                top_of = `T16W_TOP_9BIT;
            end
            `T16W_M_PC10, `T16W_M_FP10: begin
                top_of = `T16W_TOP_10BIT;
            end
            `T16W_M_CTC_MA, `T16W_M_PFC_MA, `T16W_M_PC_MA,
            `T16W_M_FP_MA: begin
                top_of = ma;
            end
            `T16W_M_CTC_CAP, `T16W_M_PFC_CAP, `T16W_M_PC_CAP,
            `T16W_M_FP_CAP: begin
                top_of = cap;
            end
            default: begin
                top_of = `T16W_MAX;
            end
        endcase
    endfunction

    // Code 01 outside non-PWM is legal only for channel A in a few modes
    function automatic logic toggle_ok(input logic [3:0] m,
                                       input logic is_a);
        case (mode_class(m))
            T16W_CLS_FAST: begin
                toggle_ok = is_a &&
                    (m == `T16W_M_FP_CAP || m == `T16W_M_FP_MA);
            end
            T16W_CLS_DUAL: begin
                toggle_ok = is_a &&
                    (m == `T16W_M_PFC_MA || m == `T16W_M_PC_MA);
            end
            default: begin
                toggle_ok = 1'b1;
            end
        endcase
    endfunction

    function automatic logic connected(input logic [3:0] m,
                                       input logic [1:0] code,
                                       input logic is_a);
        connected = (code != `T16W_OUT_OFF) && (m != `T16W_M_RESERVED) &&
            !(code == `T16W_OUT_TOGGLE && !toggle_ok(m, is_a));
    endfunction

    // Next level of one waveform output for one counter step
    function automatic logic wave_step(input logic [3:0] m,
                                       input logic [1:0] code,
                                       input logic cur,
                                       input logic hit,
                                       input logic hit_is_top,
                                       input logic bot,
                                       input logic up);
        logic nxt;
        nxt = cur;
        case (mode_class(m))
            T16W_CLS_FAST: begin
                // Match wins over BOTTOM when both fall on one step
                if (code[1] && bot) begin
                    nxt = !code[0];
                end
                if (code[1] && hit && !hit_is_top) begin
                    nxt = code[0];
                end
                if (code == `T16W_OUT_TOGGLE && hit) begin
                    nxt = !cur;
                end
            end
            T16W_CLS_DUAL: begin
                if (code[1] && hit) begin
                    nxt = up ? code[0] : !code[0];
                end
                if (code == `T16W_OUT_TOGGLE && hit) begin
                    nxt = !cur;
                end
            end
            default: begin
                if (hit && code == `T16W_OUT_TOGGLE) begin
                    nxt = !cur;
                end
                if (hit && code[1]) begin
                    nxt = code[0];
                end
            end
        endcase
        wave_step = nxt;
    endfunction

    // [R11] mode assembly
    assign waveform_mode_sel = {st_ff.ctrl_b[`T16W_FLD_WAVE_HI],
                                st_ff.ctrl_a[`T16W_FLD_WAVE_LO]};
    assign out_mode_chan_a = st_ff.ctrl_a[`T16W_FLD_OUT_A];
    assign out_mode_chan_b = st_ff.ctrl_a[`T16W_FLD_OUT_B];
    // [R16] family select
    assign cls = mode_class(waveform_mode_sel);
    // [R13] [R14] [R15] TOP source
    assign top = top_of(waveform_mode_sel, st_ff.capture, st_ff.cmp_a);

    always_comb begin
        // [R12] [R13] [R14] [R15] update point per family
        case (cls)
            T16W_CLS_FAST: begin
                upd = T16W_UPD_BOTTOM;
            end
            T16W_CLS_DUAL: begin
                if (waveform_mode_sel == `T16W_M_PFC_CAP ||
                    waveform_mode_sel == `T16W_M_PFC_MA) begin
                    upd = T16W_UPD_BOTTOM;
                end else begin
                    upd = T16W_UPD_TOP;
                end
            end
            default: begin
                upd = T16W_UPD_NOW;
            end
        endcase
    end

    assign step = clk_en && cnt_tick;
    assign at_top = cnt_value == top;
    assign at_bot = cnt_value == `T16W_BOTTOM;
    assign at_max = cnt_value == `T16W_MAX;
    assign match_a = step && cnt_value == st_ff.cmp_a;
    assign match_b = step && cnt_value == st_ff.cmp_b;
    // [R1] [R4] [R8] [R17] pin takeover
    assign conn_a = connected(waveform_mode_sel, out_mode_chan_a, 1'b1);
    assign conn_b = connected(waveform_mode_sel, out_mode_chan_b, 1'b0);

    always_comb begin
        // [R12] [R13] [R14] [R15] overflow point per family
        case (cls)
            T16W_CLS_FAST: begin
                ovf_evt = step && at_top;
            end
            T16W_CLS_DUAL: begin
                ovf_evt = step && at_bot;
            end
            default: begin
                ovf_evt = step && at_max;
            end
        endcase
    end

    always_comb begin
        case (upd)
            T16W_UPD_TOP: begin
                reload = step && at_top;
            end
            T16W_UPD_BOTTOM: begin
                reload = step && at_bot;
            end
            default: begin
                reload = 1'b1;
            end
        endcase
    end

    always_comb begin
        logic [2:0] evt;
        evt = {match_b, match_a, ovf_evt};
        nxt_st = st_ff;
        if (clk_en) begin
            nxt_st.rdata = `T16W_RST_16;
            if (reg_wr) begin
                case (reg_addr)
                    `T16W_ADDR_CTRL_A: begin
                        nxt_st.ctrl_a = reg_wdata[7:0] & `T16W_CTRL_A_MASK;
                    end
                    `T16W_ADDR_CTRL_B: begin
                        nxt_st.ctrl_b = reg_wdata[7:0] & `T16W_CTRL_B_MASK;
                    end
                    `T16W_ADDR_CAPTURE: begin
                        nxt_st.capture = reg_wdata;
                    end
                    `T16W_ADDR_MATCH_A: begin
                        nxt_st.buf_a = reg_wdata;
                    end
                    `T16W_ADDR_MATCH_B: begin
                        nxt_st.buf_b = reg_wdata;
                    end
                    `T16W_ADDR_IRQ_STAT: begin
                        nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata[2:0];
                    end
                    `T16W_ADDR_IRQ_MASK: begin
                        nxt_st.irq_mask = reg_wdata[2:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `T16W_ADDR_CTRL_A: begin
                        nxt_st.rdata = {8'h00, st_ff.ctrl_a};
                    end
                    `T16W_ADDR_CTRL_B: begin
                        nxt_st.rdata = {8'h00, st_ff.ctrl_b};
                    end
                    `T16W_ADDR_CAPTURE: begin
                        nxt_st.rdata = st_ff.capture;
                    end
                    `T16W_ADDR_MATCH_A: begin
                        nxt_st.rdata = st_ff.buf_a;
                    end
                    `T16W_ADDR_MATCH_B: begin
                        nxt_st.rdata = st_ff.buf_b;
                    end
                    `T16W_ADDR_IRQ_STAT: begin
                        nxt_st.rdata = {13'h0000, st_ff.irq_stat};
                    end
                    `T16W_ADDR_IRQ_MASK: begin
                        nxt_st.rdata = {13'h0000, st_ff.irq_mask};
                    end
                    default: begin
                        nxt_st.rdata = `T16W_RST_16;
                    end
                endcase
            end
            // Set wins over a write-one clear in the same cycle
            nxt_st.irq_stat = nxt_st.irq_stat | evt;
            // Immediate modes reload every cycle, so a write reaches the compare one cycle after the buffer
            if (reload) begin
                nxt_st.cmp_a = st_ff.buf_a;
                nxt_st.cmp_b = st_ff.buf_b;
            end
            // [R3] [R5] [R6] [R7] [R9] [R10] output actions
            if (step) begin
                nxt_st.wave_a = wave_step(waveform_mode_sel,
                    out_mode_chan_a, st_ff.wave_a, match_a,
                    st_ff.cmp_a == top, at_bot, cnt_up);
                nxt_st.wave_b = wave_step(waveform_mode_sel,
                    out_mode_chan_b, st_ff.wave_b, match_b,
                    st_ff.cmp_b == top, at_bot, cnt_up);
            end
            // [R1] [R2] port mux, direction bit gates the driver
            nxt_st.pin_a = conn_a ? st_ff.wave_a : port_data_a;
            nxt_st.pin_b = conn_b ? st_ff.wave_b : port_data_b;
            nxt_st.drv_a = port_dir_a;
            nxt_st.drv_b = port_dir_b;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign top_value = top;
    assign wave_class = cls;
    assign overflow_flag = ovf_evt;
    assign wave_out_a = st_ff.pin_a;
    assign wave_out_b = st_ff.pin_b;
    assign wave_oe_n_a = !st_ff.drv_a;
    assign wave_oe_n_b = !st_ff.drv_b;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_port_takeover_a: assert property ( // [R1]
        clk_en && !conn_a |=> wave_out_a == $past(port_data_a))
        else $error("pin A not on port data while disconnected");
    a_nonpwm_set_a: assert property ( // [R3]
        cls == T16W_CLS_NONPWM && waveform_mode_sel != `T16W_M_RESERVED
        && out_mode_chan_a == `T16W_OUT_SET && match_a
        |=> st_ff.wave_a ##1 wave_out_a || !conn_a)
        else $error("non-PWM set on match failed");
    a_nonpwm_toggle_a: assert property ( // [R3]
        cls == T16W_CLS_NONPWM && out_mode_chan_a == `T16W_OUT_TOGGLE
        && match_a |=> st_ff.wave_a != $past(st_ff.wave_a))
        else $error("non-PWM toggle failed");
    a_fast_b_off: assert property ( // [R4]
        cls == T16W_CLS_FAST && out_mode_chan_b == `T16W_OUT_TOGGLE
        |-> !conn_b)
        else $error("fast PWM code 01 connected channel B");
    a_fast_bottom_set: assert property ( // [R5]
        cls == T16W_CLS_FAST && out_mode_chan_a == `T16W_OUT_CLEAR
        && step && at_bot && !match_a |=> st_ff.wave_a)
        else $error("fast PWM did not set at BOTTOM");
    a_fast_top_ignore: assert property ( // [R7]
        cls == T16W_CLS_FAST && out_mode_chan_a[1] && match_a
        && st_ff.cmp_a == top && !at_bot
        |=> st_ff.wave_a == $past(st_ff.wave_a))
        else $error("fast PWM acted on a match at TOP");
    a_dual_up_clear: assert property ( // [R9]
        cls == T16W_CLS_DUAL && out_mode_chan_b == `T16W_OUT_CLEAR
        && match_b && cnt_up |=> !st_ff.wave_b)
        else $error("dual-slope up match did not clear");
    a_dual_down_clear: assert property ( // [R10]
        cls == T16W_CLS_DUAL && out_mode_chan_b == `T16W_OUT_SET
        && match_b && !cnt_up |=> !st_ff.wave_b)
        else $error("dual-slope down match did not clear");
    a_top_pc8_fixed: assert property ( // [R13]
        waveform_mode_sel == `T16W_M_PC8 |-> top_value == `T16W_TOP_8BIT)
        else $error("phase-correct 8-bit TOP wrong");
    a_ovf_fast_top: assert property ( // [R14]
        cls == T16W_CLS_FAST && step && at_top
        |=> st_ff.irq_stat[`T16W_IRQ_OVF])
        else $error("fast PWM overflow not flagged at TOP");

endmodule // t16w_wave
